// ==== hw/sesf_framer.sv ====
// Sensor event stream framer: timestamps, record layout and stream delimiting
`timescale 1ns/1ps
`default_nettype none
module sesf_framer
   import sesf_pkg::*;
#(
   parameter int unsigned TICK_CYC = TS_TICK_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_evt_valid,
   output logic o_evt_ready,
   input wire logic [7:0] i_evt_id,
   input wire logic [2:0] i_evt_fmt,
   input wire logic [2:0] i_evt_slen,
   input wire logic i_evt_no_acc,
   input wire logic [79:0] i_evt_data,
   input wire logic i_align_req,
   input wire logic i_pad_req,
   output logic o_ctl_ready,
   output logic o_byte_valid,
   output logic [7:0] o_byte_data,
   output logic o_byte_last,
   input wire logic i_byte_ready,
   output logic [TS_W-1:0] o_time
);

   localparam int unsigned RB = 8 * REC_MAX_BYTES;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_REC = 2'b01
   } sesf_state_t;

   sesf_state_t state_q;
   sesf_state_t state_d;
   logic [RB-1:0] rec_q;
   logic [3:0] rec_len_q;
   logic [TS_W-1:0] last_ts_q;
   logic had_ts_q;
   logic odd_q;
   logic [TS_W-1:0] now;
   logic ser_idle;
   logic [RB-1:0] rec_d;
   logic [RB-1:0] ts_bytes;
   logic [3:0] ts_len;
   logic [RB-1:0] ld_bytes;
   logic [3:0] ld_len;

   // ------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------
   sesf_timebase #(
      .TICK_CYC(TICK_CYC)
   ) u_timebase (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .o_tick(),
      .o_time(now)
   );

   // ------------------------------------------------------------
   // Handshakes and decode
   // ------------------------------------------------------------
   wire sesf_fmt_t fmt = sesf_fmt_t'(i_evt_fmt);
   wire logic evt_take = i_evt_valid && o_evt_ready;
   wire logic align_take = i_align_req && o_ctl_ready;
   wire logic pad_take = i_pad_req && !i_align_req && o_ctl_ready;
   wire logic fill_ld = align_take && odd_q;
   wire logic rec_ld = (state_q == ST_REC) && ser_idle;
   wire logic byte_fire = o_byte_valid && i_byte_ready;
   wire logic [TS_W-1:0] elapsed = now - last_ts_q;
   wire logic fits_small = (elapsed[TS_W-1:8] == '0);
   wire logic fits_large = (elapsed[TS_W-1:16] == '0);
   wire logic need_ts = !had_ts_q || (elapsed != '0);
   wire logic use_full = !had_ts_q || !fits_large;
   wire logic [15:0] acc_word = i_evt_no_acc ? 16'h0000 : i_evt_data[79:64];
   wire logic [15:0] act_word = i_evt_data[15:0] & ACT_RSV_MASK;
   wire logic ser_load = evt_take || rec_ld || fill_ld || pad_take;

   assign o_evt_ready = (state_q == ST_IDLE) && ser_idle;
   assign o_ctl_ready = (state_q == ST_IDLE) && ser_idle && !i_evt_valid;

   // ------------------------------------------------------------
   // Sensor record layout, identifier in the lowest byte
   // ------------------------------------------------------------
   // No time field exists in any layout below
   always_comb begin
      rec_d = '0;
      case (fmt)
         FMT_QUAT: rec_d = RB'({acc_word, i_evt_data[63:0], i_evt_id}); // RULE3 RULE4 RULE5
         FMT_EULER: rec_d = RB'({i_evt_data[47:0], i_evt_id}); // RULE6
         FMT_VEC3: rec_d = RB'({i_evt_data[47:0], i_evt_id}); // RULE7
         FMT_ACT: rec_d = RB'({act_word, i_evt_id}); // RULE8 RULE9
         FMT_SCALAR: rec_d = RB'({i_evt_data[39:0], i_evt_id}); // RULE10
         default: rec_d = RB'(i_evt_id); // RULE11
      endcase
   end // RULE12

   // ------------------------------------------------------------
   // Timestamp record, shortest kind that holds the delta
   // ------------------------------------------------------------
   always_comb begin
      if (use_full) begin
         ts_bytes = RB'({now, ID_TS_FULL}); // RULE15
         ts_len = LEN_TS_FULL;
      end else if (fits_small) begin
         ts_bytes = RB'({elapsed[7:0], ID_TS_SMALL}); // RULE19
         ts_len = LEN_TS_SMALL;
      end else begin
         ts_bytes = RB'({elapsed[15:0], ID_TS_LARGE}); // RULE19
         ts_len = LEN_TS_LARGE;
      end
   end

   // ------------------------------------------------------------
   // Serializer feed: timestamp first, then its record
   // ------------------------------------------------------------
   always_comb begin
      ld_bytes = RB'(ID_PADDING); // RULE17
      ld_len = LEN_EVENT;
      if (evt_take && need_ts) begin
         ld_bytes = ts_bytes; // RULE13
         ld_len = ts_len;
      end else if (evt_take) begin
         ld_bytes = rec_d; // RULE1
         ld_len = sesf_rec_len(fmt, i_evt_slen); // RULE2
      end else if (rec_ld) begin
         ld_bytes = rec_q;
         ld_len = rec_len_q;
      end else if (fill_ld) begin
         ld_bytes = RB'(ID_FILLER); // RULE16
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: if (evt_take && need_ts) state_d = ST_REC;
         ST_REC: if (ser_idle) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         state_q <= ST_IDLE;
         rec_q <= '0;
         rec_len_q <= LEN_EVENT;
         last_ts_q <= '0;
         had_ts_q <= 1'b0;
         odd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (evt_take) begin
            rec_q <= rec_d;
            rec_len_q <= sesf_rec_len(fmt, i_evt_slen);
         end
         if (evt_take && need_ts) begin
            last_ts_q <= now; // RULE13
            had_ts_q <= 1'b1;
         end
         if (byte_fire) begin
            odd_q <= !odd_q; // RULE16
         end
      end
   end

   sesf_byte_ser #(
      .MAX_BYTES(REC_MAX_BYTES)
   ) u_ser (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_load(ser_load),
      .i_bytes(ld_bytes),
      .i_len(ld_len),
      .o_idle(ser_idle),
      .o_valid(o_byte_valid),
      .o_data(o_byte_data),
      .o_last(o_byte_last),
      .i_ready(i_byte_ready)
   );

   assign o_time = now;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [3:0] cnt_h;
   logic [3:0] len_h;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         cnt_h <= '0;
         len_h <= '0;
      end else if (ser_load && ser_idle) begin
         cnt_h <= '0;
         len_h <= ld_len;
      end else if (byte_fire) begin
         cnt_h <= cnt_h + 4'h1;
      end
   end

   property p_len_fixed;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      byte_fire && o_byte_last |-> cnt_h + 4'h1 == len_h;
   endproperty
   a_len_fixed: assert property (p_len_fixed) else $error("record length wrong"); // RULE2

   property p_id_first;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      evt_take && had_ts_q && elapsed == '0 |=> o_byte_valid && o_byte_data == $past(i_evt_id);
   endproperty
   a_id_first: assert property (p_id_first) else $error("record not led by id"); // RULE1

   property p_acc_zero;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      evt_take && fmt == FMT_QUAT && i_evt_no_acc |=> rec_q[87:72] == 16'h0000;
   endproperty
   a_acc_zero: assert property (p_acc_zero) else $error("accuracy not zero"); // RULE5

   property p_act_rsv;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      evt_take && fmt == FMT_ACT |=> !rec_q[15] && !rec_q[23] && rec_len_q == LEN_ACT;
   endproperty
   a_act_rsv: assert property (p_act_rsv) else $error("reserved activity bit set"); // RULE9

   property p_first_full;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      evt_take && !had_ts_q |=> o_byte_data == ID_TS_FULL ##0 state_q == ST_REC;
   endproperty
   a_first_full: assert property (p_first_full) else $error("first stamp not full"); // RULE15

   property p_small_delta;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      evt_take && had_ts_q && elapsed != '0 && fits_small
         |=> o_byte_data == ID_TS_SMALL ##1 o_byte_valid;
   endproperty
   a_small_delta: assert property (p_small_delta) else $error("small delta not chosen"); // RULE19

   property p_filler;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      align_take && odd_q |=> o_byte_valid && o_byte_data == ID_FILLER && o_byte_last;
   endproperty
   a_filler: assert property (p_filler) else $error("filler missing"); // RULE16

   property p_pad;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      pad_take |=> o_byte_valid && o_byte_data == ID_PADDING && o_byte_last;
   endproperty
   a_pad: assert property (p_pad) else $error("padding missing"); // RULE17

   // ------------------------------------------------------------
   // Stream ordering checks
   // ------------------------------------------------------------
   property p_large_delta;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      evt_take && had_ts_q && !fits_small && fits_large |=> o_byte_data == ID_TS_LARGE;
   endproperty
   a_large_delta: assert property (p_large_delta) else $error("large delta missing"); // RULE19

   property p_stamp_base;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      evt_take && need_ts |=> had_ts_q && last_ts_q == $past(now);
   endproperty
   a_stamp_base: assert property (p_stamp_base) else $error("stamp base not kept"); // RULE13

   property p_rec_follow;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      rec_ld |=> o_byte_valid && o_byte_data == $past(rec_q[7:0]);
   endproperty
   a_rec_follow: assert property (p_rec_follow) else $error("record lost after stamp"); // RULE13

   property p_hold_stall;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      o_byte_valid && !i_byte_ready
         |=> o_byte_valid && $stable(o_byte_data) && $stable(o_byte_last);
   endproperty
   a_hold_stall: assert property (p_hold_stall) else $error("stalled byte moved"); // RULE2

   property p_no_mix;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      o_byte_valid |-> !o_evt_ready && !o_ctl_ready;
   endproperty
   a_no_mix: assert property (p_no_mix) else $error("request taken mid record"); // RULE1

   property p_ready_after;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      byte_fire && o_byte_last && state_q == ST_IDLE |=> o_evt_ready;
   endproperty
   a_ready_after: assert property (p_ready_after) else $error("ready late after record"); // RULE2

   property p_even_no_fill;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      align_take && !odd_q |=> !o_byte_valid;
   endproperty
   a_even_no_fill: assert property (p_even_no_fill) else $error("filler on even count"); // RULE16

   c_quat: cover property (@(posedge i_core_clk) evt_take && fmt == FMT_QUAT);
   c_large: cover property (@(posedge i_core_clk) evt_take && had_ts_q && !fits_small
      && fits_large);
   c_full_again: cover property (@(posedge i_core_clk) evt_take && had_ts_q && !fits_large);
   c_filler: cover property (@(posedge i_core_clk) align_take && odd_q);
   c_pad: cover property (@(posedge i_core_clk) pad_take);

endmodule
`default_nettype wire

// ==== hw/sesf_pkg.sv ====
// Constants and types for the sensor event stream framer
// Functional notes
// [RULE1] Each record opens with one identifier byte, then that type's payload bytes.
// [RULE2] Record length is fixed per identifier and counts the identifier byte.
// [RULE3] Quaternion bytes 1-8 carry X,Y,Z,W signed 16-bit, low byte first.
// [RULE4] Quaternion bytes 9-10 carry unsigned 16-bit accuracy, low byte first.
// [RULE5] Rotation vector without magnetic reference always reports zero accuracy.
// [RULE6] Orientation record carries heading, pitch, roll as signed 16-bit, low first.
// [RULE7] Vector record carries X,Y,Z signed 16-bit in bytes 1-6, low first.
// [RULE8] Activity record carries 16-bit change bitmap in bytes 1-2, low first.
// [RULE9] Bitmap bits 0-6 end, 8-14 start activities; bits 7 and 15 reserved.
// [RULE10] Scalar record carries 1 to 5 payload bytes, low byte first.
// [RULE11] Occurrence event record is its identifier byte alone.
// [RULE12] Time is never inside a sensor record; it travels in timestamp records.
// [RULE13] A timestamp applies to all following records until the next one.
// [RULE14] Time base is a 40-bit counter at 1/64000 s, zero at boot, wrapping.
// [RULE15] Timestamp kinds: full 40-bit, small 8-bit delta, large 16-bit delta.
// [RULE16] Identifier 255 is a filler byte that pads blocks to even length.
// [RULE17] Identifier 0 is a padding byte marking the end of a read.
// [RULE18] Reader advances by fixed lengths and tracks a running timestamp; the host model splits records at i_byte_last instead.
// [RULE19] Shortest timestamp kind whose delta fits is chosen, else a full one.
`default_nettype none
package sesf_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned TS_TICK_NS = 15625;
   localparam int unsigned TS_TICK_CYC = (TS_TICK_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned TS_W = 40;

   // ------------------------------------------------------------
   // Identifiers and lengths
   // ------------------------------------------------------------
   localparam logic [7:0] ID_TS_SMALL = 8'hfb;
   localparam logic [7:0] ID_TS_LARGE = 8'hfc;
   localparam logic [7:0] ID_TS_FULL = 8'hfd;
   localparam logic [7:0] ID_FILLER = 8'hff;
   localparam logic [7:0] ID_PADDING = 8'h00;

   localparam int unsigned REC_MAX_BYTES = 11;
   localparam logic [3:0] LEN_EVENT = 4'h1;
   localparam logic [3:0] LEN_QUAT = 4'hb;
   localparam logic [3:0] LEN_EULER = 4'h7;
   localparam logic [3:0] LEN_VEC3 = 4'h7;
   localparam logic [3:0] LEN_ACT = 4'h3;
   localparam logic [3:0] LEN_TS_SMALL = 4'h2;
   localparam logic [3:0] LEN_TS_LARGE = 4'h3;
   localparam logic [3:0] LEN_TS_FULL = 4'h6;
   localparam logic [2:0] SCALAR_MIN = 3'h1;
   localparam logic [2:0] SCALAR_MAX = 3'h5;
   localparam logic [15:0] ACT_RSV_MASK = 16'h7f7f;

   typedef enum logic [2:0] {
      FMT_EVENT = 3'b000,
      FMT_QUAT = 3'b001,
      FMT_EULER = 3'b010,
      FMT_VEC3 = 3'b011,
      FMT_ACT = 3'b100,
      FMT_SCALAR = 3'b101
   } sesf_fmt_t;

   function automatic logic [2:0] sesf_scalar_len(input logic [2:0] slen);
      if (slen < SCALAR_MIN) begin
         return SCALAR_MIN;
      end
      if (slen > SCALAR_MAX) begin
         return SCALAR_MAX;
      end
      return slen;
   endfunction

   function automatic logic [3:0] sesf_rec_len(input sesf_fmt_t fmt, input logic [2:0] slen);
      case (fmt)
         FMT_QUAT: return LEN_QUAT;
         FMT_EULER: return LEN_EULER;
         FMT_VEC3: return LEN_VEC3;
         FMT_ACT: return LEN_ACT;
         FMT_SCALAR: return {1'b0, sesf_scalar_len(slen)} + 4'h1;
         default: return LEN_EVENT;
      endcase
   endfunction

endpackage
`default_nettype wire

// ==== hw/sesf_timebase.sv ====
// Event time base: 64 kHz tick divider and 40-bit time counter
`timescale 1ns/1ps
`default_nettype none
module sesf_timebase
   import sesf_pkg::*;
#(
   parameter int unsigned TICK_CYC = TS_TICK_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   output logic o_tick,
   output logic [TS_W-1:0] o_time
);

   localparam int unsigned DIV_W = $clog2(TICK_CYC + 1);

   logic [DIV_W-1:0] div_q;
   logic [TS_W-1:0] time_q;
   wire logic tick = (div_q == DIV_W'(TICK_CYC - 1));

   // ------------------------------------------------------------
   // Divider and counter
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         div_q <= '0;
         time_q <= '0;
      end else begin
         div_q <= tick ? '0 : div_q + DIV_W'(1);
         if (tick) begin
            time_q <= time_q + TS_W'(1); // RULE14
         end
      end
   end

   assign o_tick = tick;
   assign o_time = time_q;

   property p_time_step;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      o_tick |=> o_time == $past(o_time) + TS_W'(1);
   endproperty
   a_time_step: assert property (p_time_step) else $error("time base did not step"); // RULE14

endmodule
`default_nettype wire

// ==== hw/sesf_byte_ser.sv ====
// Record serializer: loads one record and shifts it out byte by byte
`timescale 1ns/1ps
`default_nettype none
module sesf_byte_ser
#(
   parameter int unsigned MAX_BYTES = 11
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_load,
   input wire logic [8*MAX_BYTES-1:0] i_bytes,
   input wire logic [$clog2(MAX_BYTES+1)-1:0] i_len,
   output logic o_idle,
   output logic o_valid,
   output logic [7:0] o_data,
   output logic o_last,
   input wire logic i_ready
);

   localparam int unsigned CNT_W = $clog2(MAX_BYTES + 1);

   logic [8*MAX_BYTES-1:0] buf_q;
   logic [CNT_W-1:0] cnt_q;
   wire logic fire = o_valid && i_ready;

   // ------------------------------------------------------------
   // Shift register, lowest byte leaves first
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         buf_q <= '0;
         cnt_q <= '0;
      end else if (i_load && o_idle) begin
         buf_q <= i_bytes;
         cnt_q <= i_len;
      end else if (fire) begin
         buf_q <= buf_q >> 8;
         cnt_q <= cnt_q - CNT_W'(1);
      end
   end

   assign o_idle = (cnt_q == '0);
   assign o_valid = !o_idle;
   assign o_data = buf_q[7:0];
   assign o_last = (cnt_q == CNT_W'(1));

endmodule
`default_nettype wire

// ==== sim/sesf_host_model.sv ====
// Host side model: takes stream bytes and parses records with a running timestamp
`timescale 1ns/1ps
`default_nettype none
module sesf_host_model (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_slow,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte_data,
   input wire logic i_byte_last,
   output logic o_byte_ready
);
   logic [7:0] buf_q [0:1023];
   int n_q, cur_q, lrs_q, lrl_q, prs_q, nst_q;
   logic [39:0] ts_q;
   logic tog_q, parse_q, stop_q;
   // Slow mode offers ready every other cycle only
   assign o_byte_ready = !i_slow || tog_q;
   always @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         n_q <= 0;
         cur_q <= 0;
         lrs_q <= 0;
         lrl_q <= 0;
         prs_q <= 0;
         nst_q <= 0;
         ts_q <= 40'h0;
         tog_q <= 1'b0;
         parse_q <= 1'b0;
         stop_q <= 1'b0;
      end else begin
         tog_q <= !tog_q;
         parse_q <= 1'b0;
         if (i_byte_valid && o_byte_ready) begin
            buf_q[n_q[9:0]] <= i_byte_data;
            n_q <= n_q + 1;
            if (i_byte_last) begin
               prs_q <= lrs_q;
               lrs_q <= cur_q;
               lrl_q <= n_q + 1 - cur_q;
               cur_q <= n_q + 1;
               parse_q <= 1'b1;
            end
         end
         if (parse_q) begin
            stop_q <= (buf_q[lrs_q[9:0]] == 8'h00);
            case (buf_q[lrs_q[9:0]])
               8'hfd: ts_q <= {buf_q[lrs_q[9:0]+5], buf_q[lrs_q[9:0]+4], buf_q[lrs_q[9:0]+3],
                               buf_q[lrs_q[9:0]+2], buf_q[lrs_q[9:0]+1]};
               8'hfb: ts_q <= ts_q + buf_q[lrs_q[9:0]+1];
               8'hfc: ts_q <= ts_q + {buf_q[lrs_q[9:0]+2], buf_q[lrs_q[9:0]+1]};
               default: ;
            endcase
            if (buf_q[lrs_q[9:0]] >= 8'hfb && buf_q[lrs_q[9:0]] <= 8'hfd) begin
               nst_q <= nst_q + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/sesf_framer_bench.sv ====
// Self-checking bench for the sensor event stream framer
`timescale 1ns/1ps
`default_nettype none
module sesf_framer_bench;
   import sesf_pkg::*;
   localparam int TK = 64;
   logic clk = 1'b0, rst_n = 1'b0, ev_v = 1'b0, no_acc = 1'b0, al = 1'b0, pd = 1'b0;
   logic slow = 1'b0;
   logic [7:0] ev_id = 8'h00;
   logic [2:0] ev_fmt = 3'h0, ev_slen = 3'h0;
   logic [79:0] ev_d = 80'h0;
   logic ev_rdy, ctl_rdy, b_v, b_last, b_rdy;
   logic [7:0] b_d;
   logic [TS_W-1:0] now;
   int num_errors = 0, checked = 0, cyc = 0;
   always #2.5 clk = !clk;
   sesf_framer #(.TICK_CYC(TK)) i_sesf_framer (.i_core_clk(clk), .i_reset_n(rst_n),
      .i_evt_valid(ev_v), .o_evt_ready(ev_rdy), .i_evt_id(ev_id), .i_evt_fmt(ev_fmt),
      .i_evt_slen(ev_slen), .i_evt_no_acc(no_acc), .i_evt_data(ev_d), .i_align_req(al),
      .i_pad_req(pd), .o_ctl_ready(ctl_rdy), .o_byte_valid(b_v), .o_byte_data(b_d),
      .o_byte_last(b_last), .i_byte_ready(b_rdy), .o_time(now));
   sesf_host_model i_sesf_host_model (.i_core_clk(clk), .i_reset_n(rst_n), .i_slow(slow),
      .i_byte_valid(b_v), .i_byte_data(b_d), .i_byte_last(b_last), .o_byte_ready(b_rdy));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   function automatic logic [7:0] byte_at(input int k);
      return i_sesf_host_model.buf_q[k];
   endfunction
   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic settle();
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (!(ev_rdy === 1'b1 && b_v === 1'b0) && k < 300);
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic ev(input logic [7:0] id, input logic [2:0] fmt, input logic [2:0] sl,
                     input logic na, input logic [79:0] d);
      int k;
      @(posedge clk);
      #1;
      ev_v = 1'b1;
      ev_id = id;
      ev_fmt = fmt;
      ev_slen = sl;
      no_acc = na;
      ev_d = d;
      k = 0;
      while (ev_rdy !== 1'b1 && k < 300) begin
         @(negedge clk);
         k++;
      end
      @(posedge clk);
      #1 ev_v = 1'b0;
      settle();
   endtask
   task automatic ctl(input logic a, input logic p);
      int k;
      @(posedge clk);
      #1;
      al = a;
      pd = p;
      k = 0;
      while (ctl_rdy !== 1'b1 && k < 300) begin
         @(negedge clk);
         k++;
      end
      @(posedge clk);
      #1;
      al = 1'b0;
      pd = 1'b0;
      settle();
   endtask
   task automatic chk_rec(input logic [7:0] id, input logic [79:0] pay, input int len);
      int s;
      s = i_sesf_host_model.lrs_q;
      chk("record length", 40'(i_sesf_host_model.lrl_q), 40'(len));
      chk("record id", byte_at(s), id);
      for (int k = 1; k < len; k++) begin
         chk("payload byte", byte_at(s + k), pay[8*k-8 +: 8]);
      end
   endtask
   task automatic sync(input int n);
      logic [TS_W-1:0] t;
      int k;
      repeat (n) begin
         t = now;
         k = 0;
         while (now === t && k < 2 * TK) begin
            @(negedge clk);
            k++;
         end
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_first();
      int p;
      ev(8'h22, 3'h1, 3'h0, 1'b0, 80'h0a09_0807_0605_0403_0201);
      p = i_sesf_host_model.prs_q;
      chk("first stamp id", byte_at(p), ID_TS_FULL);
      chk("first stamp length", 40'(i_sesf_host_model.lrs_q - p), 40'(LEN_TS_FULL));
      chk("time at boot", i_sesf_host_model.ts_q, 40'h0);
      chk_rec(8'h22, 80'h0a09_0807_0605_0403_0201, 11);
      $display("test first done");
   endtask
   task automatic t_layout();
      logic [79:0] d;
      d = 80'hfedc_ba98_7654_3210_ffff;
      slow = 1'b1;
      ev(8'h23, 3'h1, 3'h0, 1'b1, d);
      chk_rec(8'h23, {16'h0, d[63:0]}, 11);
      slow = 1'b0;
      ev(8'h43, 3'h2, 3'h0, 1'b0, d);
      chk_rec(8'h43, d, 7);
      ev(8'h01, 3'h3, 3'h0, 1'b0, d);
      chk_rec(8'h01, d, 7);
      ev(8'h3f, 3'h4, 3'h0, 1'b0, d);
      chk_rec(8'h3f, {64'h0, d[15:0] & 16'h7f7f}, 3);
      for (int n = 1; n <= 5; n++) begin
         ev(8'h80, 3'h5, 3'(n), 1'b0, d);
         chk_rec(8'h80, d, n + 1);
      end
      ev(8'h80, 3'h5, 3'h0, 1'b0, d);
      chk_rec(8'h80, d, 2);
      ev(8'h80, 3'h5, 3'h7, 1'b0, d);
      chk_rec(8'h80, d, 6);
      ev(8'h37, 3'h0, 3'h0, 1'b0, d);
      chk_rec(8'h37, d, 1);
      ev(8'h39, 3'h7, 3'h0, 1'b0, d);
      chk_rec(8'h39, d, 1);
      $display("test layout done");
   endtask
   task automatic t_share();
      int s;
      sync(1);
      ev(8'h37, 3'h0, 3'h0, 1'b0, 80'h0);
      s = i_sesf_host_model.nst_q;
      ev(8'h38, 3'h0, 3'h0, 1'b0, 80'h0);
      chk("stamp count", 40'(i_sesf_host_model.nst_q), 40'(s));
      chk("record before", byte_at(i_sesf_host_model.prs_q), 8'h37);
      $display("test share done");
   endtask
   task automatic t_gap(input int n, input logic [7:0] id, input int len);
      logic [39:0] t;
      int p;
      sync(1);
      ev(8'h37, 3'h0, 3'h0, 1'b0, 80'h0);
      t = i_sesf_host_model.ts_q;
      sync(n);
      ev(8'h38, 3'h0, 3'h0, 1'b0, 80'h0);
      p = i_sesf_host_model.prs_q;
      chk("stamp id", byte_at(p), id);
      chk("stamp length", 40'(i_sesf_host_model.lrs_q - p), 40'(len));
      chk("running time", i_sesf_host_model.ts_q - t, 40'(n));
      $display("test gap %0d done", n);
   endtask
   task automatic t_time();
      logic [TS_W-1:0] t;
      sync(1);
      t = now;
      repeat (5 * TK) @(posedge clk);
      #1;
      chk("time step", now - t, 40'h5);
      $display("test time done");
   endtask
   task automatic t_ctl();
      int k;
      ctl(1'b1, 1'b0);
      chk("parity after align", 40'(i_sesf_host_model.n_q % 2), 40'h0);
      ctl(1'b0, 1'b1);
      chk_rec(ID_PADDING, 80'h0, 1);
      chk("reader stopped", 40'(i_sesf_host_model.stop_q), 40'h1);
      ctl(1'b1, 1'b0);
      chk_rec(ID_FILLER, 80'h0, 1);
      k = i_sesf_host_model.n_q;
      ctl(1'b1, 1'b0);
      chk("no filler when even", 40'(i_sesf_host_model.n_q), 40'(k));
      ctl(1'b0, 1'b1);
      ctl(1'b1, 1'b1);
      chk_rec(ID_FILLER, 80'h0, 1);
      chk("parity after both", 40'(i_sesf_host_model.n_q % 2), 40'h0);
      $display("test control done");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      t_first();
      t_layout();
      t_share();
      t_gap(40, ID_TS_SMALL, 2);
      t_gap(255, ID_TS_SMALL, 2);
      t_gap(256, ID_TS_LARGE, 3);
      t_time();
      t_ctl();
      results();
   end
endmodule
`default_nettype wire
